// [hw/nco_increment_buffer.v]
// Function
// - increment is upper nibble, high byte, low byte, msb to lsb
// - shadow buffer loads all 20 bits on first oscillator falling edge after low write
// - reset loads low byte with one, clears high and upper
// - upper register bits 7-4 ignore writes and read zero
`timescale 1ns/1ps
`include "nco_increment_defs.vh"

module nco_increment_buffer (
	input  wire                   core_clk,
	input  wire                   reset_n,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [11:0]            paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	input  wire                   oscillator_source_clock,
	output reg  [19:0]            synth_increment_word,
	output reg                    transfer_pending
);

	// ----------------------------------------
	// apb access decode
	// ----------------------------------------
	wire        setup_phase;
	wire        access_done;
	wire        write_done;
	wire        hit_low;
	wire        hit_high;
	wire        hit_upper;
	wire        hit_shadow;
	wire        hit_status;
	wire        mapped;
	wire [7:0]  increment_low_byte;
	wire [7:0]  increment_high_byte;
	wire [3:0]  increment_upper_nibble;
	wire [19:0] phase_increment_value;
	wire        osc_fall;
	reg  [31:0] next_prdata;

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign write_done  = access_done & pwrite;
	assign hit_low     = (paddr == `ADDR_INC_LOW);
	assign hit_high    = (paddr == `ADDR_INC_HIGH);
	assign hit_upper   = (paddr == `ADDR_INC_UPPER);
	assign hit_shadow  = (paddr == `ADDR_SHADOW);
	assign hit_status  = (paddr == `ADDR_STATUS);
	assign mapped      = hit_low | hit_high | hit_upper | hit_shadow | hit_status;

	// ----------------------------------------
	// increment registers
	// ----------------------------------------
	byte_field_reg #(
		.WIDTH       (8),
		.RESET_VALUE (`RESET_INC_LOW)
	) u_low (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.write_en   (write_done & hit_low),
		.write_data (pwdata[7:0]),
		.value      (increment_low_byte)
	);

	byte_field_reg #(
		.WIDTH       (8),
		.RESET_VALUE (`RESET_INC_HIGH)
	) u_high (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.write_en   (write_done & hit_high),
		.write_data (pwdata[7:0]),
		.value      (increment_high_byte)
	);

	// only four bits are stored, so bits 7-4 cannot take a write
	byte_field_reg #(
		.WIDTH       (4),
		.RESET_VALUE (`RESET_INC_UPPER)
	) u_upper (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.write_en   (write_done & hit_upper),
		.write_data (pwdata[3:0]),
		.value      (increment_upper_nibble)
	);

	assign phase_increment_value = {increment_upper_nibble, increment_high_byte,
		increment_low_byte};

	// ----------------------------------------
	// shadow buffer transfer
	// ----------------------------------------
	falling_edge_detect u_osc_edge (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.level    (oscillator_source_clock),
		.fall     (osc_fall)
	);

	// a new low write in the same cycle as an edge keeps the request alive
	always @(posedge core_clk) begin
		if (!reset_n) begin
			transfer_pending     <= 1'b0;
			synth_increment_word <= `RESET_SHADOW;
		end else begin
			transfer_pending <= (write_done & hit_low) | (transfer_pending & ~osc_fall);
			if (transfer_pending & osc_fall) begin
				synth_increment_word <= phase_increment_value;
			end
		end
	end

	// ----------------------------------------
	// read data and answer
	// ----------------------------------------
	always @* begin
		next_prdata = 32'h0000_0000;
		if (hit_low) begin
			next_prdata[7:0] = increment_low_byte;
		end else if (hit_high) begin
			next_prdata[7:0] = increment_high_byte;
		end else if (hit_upper) begin
			next_prdata[3:0] = increment_upper_nibble;
		end else if (hit_shadow) begin
			next_prdata[19:0] = synth_increment_word;
		end else if (hit_status) begin
			next_prdata[`STATUS_PENDING_BIT] = transfer_pending;
		end
	end

	// one wait-free access cycle: ready is raised by the setup cycle
	always @(posedge core_clk) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (setup_phase) begin
			pready  <= 1'b1;
			pslverr <= ~mapped;
			prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

endmodule

// [hw/nco_increment_defs.vh]
`ifndef NCO_INCREMENT_DEFS_VH
`define NCO_INCREMENT_DEFS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_WIDTH           12
`define ADDR_INC_LOW         12'h000
`define ADDR_INC_HIGH        12'h004
`define ADDR_INC_UPPER       12'h008
`define ADDR_SHADOW          12'h00c
`define ADDR_STATUS          12'h010

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define INC_WIDTH            20
`define UPPER_WIDTH          4
`define RESET_INC_LOW        8'h01
`define RESET_INC_HIGH       8'h00
`define RESET_INC_UPPER      4'h0
`define RESET_SHADOW         20'h0_0001
`define STATUS_PENDING_BIT   0

`endif

// [hw/byte_field_reg.v]
`timescale 1ns/1ps

module byte_field_reg #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input  wire             core_clk,
	input  wire             reset_n,
	input  wire             write_en,
	input  wire [WIDTH-1:0] write_data,
	output reg  [WIDTH-1:0] value
);

	always @(posedge core_clk) begin
		if (!reset_n) begin
			value <= RESET_VALUE;
		end else if (write_en) begin
			value <= write_data;
		end
	end

endmodule

// [hw/falling_edge_detect.v]
`timescale 1ns/1ps

module falling_edge_detect (
	input  wire core_clk,
	input  wire reset_n,
	input  wire level,
	output wire fall
);

	reg level_prev;

	// starts low: a history of one would turn a low level at release into a false fall
	always @(posedge core_clk) begin
		if (!reset_n) begin
			level_prev <= 1'b0;
		end else begin
			level_prev <= level;
		end
	end

	assign fall = level_prev & ~level;

endmodule

// [test/nco_increment_buffer_props.sv]
`timescale 1ns/1ps
module nco_increment_buffer_props (
	input wire        core_clk,
	input wire        reset_n,
	input wire        pready,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        oscillator_source_clock,
	input wire [19:0] synth_increment_word,
	input wire        transfer_pending
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire low_wr = pready && pwrite && paddr == 12'h000;
	a_reset_word: assert property ($rose(reset_n) |-> synth_increment_word == 20'h0_0001)
		else $error("shadow reset value wrong");
	a_low_arms: assert property (low_wr |=> transfer_pending)
		else $error("low write did not arm transfer");
	a_load_clears: assert property (transfer_pending && $past(oscillator_source_clock)
		&& !oscillator_source_clock && !low_wr |=> !transfer_pending)
		else $error("transfer did not complete");
	a_word_held: assert property (!(transfer_pending && $past(oscillator_source_clock)
		&& !oscillator_source_clock) |=> $stable(synth_increment_word))
		else $error("increment changed outside transfer");
	a_upper_zero: assert property (pready && !pwrite && paddr == 12'h008 |->
		prdata[31:4] == 28'h000_0000) else $error("upper bits not zero");
	c_load: cover property (transfer_pending ##1 !transfer_pending);
	c_upper: cover property (pready && !pwrite && paddr == 12'h008);
	c_reset: cover property ($rose(reset_n));
endmodule
bind nco_increment_buffer nco_increment_buffer_props u_props (.core_clk, .reset_n, .pready,
	.pwrite, .paddr, .prdata, .oscillator_source_clock, .synth_increment_word, .transfer_pending);

// [test/nco_increment_buffer_tb_top.sv]
`timescale 1ns/1ps
module nco_increment_buffer_tb_top;
	logic        core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, osc = 0;
	logic        pready, pslverr, pend, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, x;
	logic [19:0] word, v, pv = 20'h0_0001;
	int          fail_count = 0, checked = 0, cycles = 0;
	nco_increment_buffer uut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .oscillator_source_clock(osc),
		.synth_increment_word(word), .transfer_pending(pend));
	initial forever #50 core_clk = ~core_clk;
	// hang guard, well above the longest sequence
	always @(posedge core_clk) if (++cycles == 4000) begin
		fail_count++;
		summarize();
	end
	task summarize;
		if (fail_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t %h %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk) psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk) penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one oscillator high phase then a fall
	task fall;
		osc <= 1;
		repeat (2) @(posedge core_clk);
		osc <= 0;
		repeat (3) @(posedge core_clk);
	endtask
	initial begin
		void'($urandom(20998));
		repeat (12) @(posedge core_clk);
		reset_n <= 1;
		apb(0, 12'h000, 32'h0000_0000); chk(rd, 32'h0000_0001);
		chk(32'(err), 32'h0000_0000);
		apb(0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_0000);
		apb(0, 12'h008, 32'h0000_0000); chk(rd, 32'h0000_0000);
		chk(32'(word), 32'h0000_0001);
		chk(32'(pend), 32'h0000_0000);
		for (int i = 0; i < 6; i++) begin
			x = $urandom;
			v = {x[3:0], x[15:8], x[7:0]};
			apb(1, 12'h008, x);
			apb(0, 12'h008, 32'h0000_0000); chk(rd, {28'h000_0000, x[3:0]});
			apb(1, 12'h004, x >> 8);
			chk(32'(word), 32'(pv));
			apb(1, 12'h000, x);
			@(posedge core_clk); chk(32'(pend), 32'h0000_0001);
			apb(0, 12'h010, 32'h0000_0000); chk(rd, 32'h0000_0001);
			chk(32'(word), 32'(pv));
			fall; chk(32'(word), 32'(v));
			chk(32'(pend), 32'h0000_0000);
			apb(0, 12'h00c, 32'h0000_0000); chk(rd, {12'h000, v});
			pv = v;
		end
		apb(1, 12'h004, 32'h0000_00a5);
		fall; chk(32'(word), 32'(pv));
		apb(0, 12'h020, 32'h0000_0000); chk(32'(err), 32'h0000_0001);
		reset_n <= 0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1;
		chk(32'(word), 32'h0000_0001);
		apb(0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_0000);
		apb(0, 12'h000, 32'h0000_0000); chk(rd, 32'h0000_0001);
		summarize();
	end
endmodule
